//--- hw/emt_top.sv
/*
 * External data memory interface: map decode, address routing, on-chip
 * XRAM and programmable off-chip cycle timing.
 * Assumes the core holds a request for one cycle and waits for done.
 * Off-chip cycle: setup + strobe + hold + tail = codes + 4; mux mode adds two latch phases of ale code + 1 each.
 */
`timescale 1ns/1ps
`default_nettype none
module emt_top
#(
   parameter int XRAM_AW = emt_pkg::EMT_XRAM_AW
)
(
   input  wire logic       core_clk_i,
   input  wire logic       rst_n_i,
   input  wire logic [7:0] sfr_addr_i,
   input  wire logic [7:0] sfr_wdata_i,
   input  wire logic       sfr_wr_i,
   output logic      [7:0] sfr_rdata_o,
   input  wire logic [7:0] interface_config_reg_i,
   input  wire logic [7:0] xram_page_register_i,
   input  wire logic [7:0] indirect_index_i,
   input  wire logic [15:0] data_pointer_i,
   input  wire logic       req_i,
   input  wire logic       req_wide_i,
   input  wire logic       req_write_i,
   input  wire logic [7:0] req_wdata_i,
   output logic            done_o,
   output logic      [7:0] rdata_o,
   output logic            offchip_o,
   output logic      [7:0] addr_hi_o,
   output logic            addr_hi_oe_o,
   output logic      [7:0] addr_lo_o,
   output logic            addr_lo_oe_o,
   output logic      [7:0] data_o,
   output logic            data_oe_o,
   input  wire logic [7:0] data_i,
   output logic            ale_o,
   output logic            rd_n_o,
   output logic            wr_n_o
);
   import emt_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   typedef struct packed
   {
      logic [7:0]  timing;
      logic        active;
      logic        wr;
      logic        mux;
      logic        drive_hi;
      logic [15:0] addr;
      logic [7:0]  wdata;
      logic [7:0]  rdata;
      logic        done;
      logic        offchip;
      logic [7:0]  sfr_rdata;
      logic [7:0]  addr_hi;
      logic        addr_hi_oe;
      logic [7:0]  addr_lo;
      logic        addr_lo_oe;
      logic [7:0]  dout;
      logic        dout_oe;
      logic        ale;
      logic        rd_n;
      logic        wr_n;
   } emt_top_type;

   emt_top_type r_ff;
   emt_top_type nxt_r;
   logic [7:0]  xram [2**XRAM_AW];
   logic [7:0]  xram_q;
   logic [XRAM_AW-1:0] xram_a;
   logic        xram_we;
   logic        busy_d_ff;

   emt_seq_if   sif ();

   emt_seq u_seq
   (
      .core_clk_i (core_clk_i),
      .rst_n_i    (rst_n_i),
      .sif        (sif)
   );

   ////////////////////////////////////////////////////////////////////////
   emt_map_type  map;
   logic         mux_mode;
   logic [15:0]  eff_addr;
   logic         go_off;
   logic         hi_drv;

   always_comb
   begin
      map      = emt_map_type'(interface_config_reg_i[EMT_MODE_MSB:EMT_MODE_LSB]);
      mux_mode = ~interface_config_reg_i[EMT_MUX_BIT];
      eff_addr = req_wide_i ? data_pointer_i
                 : {xram_page_register_i, indirect_index_i};
      hi_drv   = 1'b1;
      case (map)
         EMT_MAP_INTERNAL:
            go_off = 1'b0;
         EMT_MAP_SPLIT:
         begin
            go_off = (eff_addr >= 16'(EMT_XRAM_BYTES));
            hi_drv = req_wide_i;
         end
         EMT_MAP_BANK:
            go_off = (eff_addr >= 16'(EMT_XRAM_BYTES));
         EMT_MAP_EXTERNAL:
         begin
            go_off = 1'b1;
            hi_drv = req_wide_i;
         end
         default:
            go_off = 1'b0;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // On-chip XRAM; low address bits give the 4 kB wrap
   assign xram_a  = eff_addr[XRAM_AW-1:0];
   assign xram_we = req_i && !go_off && req_write_i && !r_ff.active;

   always_ff @(posedge core_clk_i)
   begin
      if (xram_we)
         xram[xram_a] <= req_wdata_i;
      xram_q <= xram[xram_a];
   end

   always_ff @(posedge core_clk_i)
      busy_d_ff <= rst_n_i ? sif.busy : 1'b0;

   ////////////////////////////////////////////////////////////////////////
   logic on_pend_ff;
   logic nxt_on_pend;

   always_comb
   begin
      nxt_r = r_ff;
      nxt_on_pend = 1'b0;
      nxt_r.done = 1'b0;
      nxt_r.sfr_rdata = (sfr_addr_i == EMT_TIMING_OFFSET) ? r_ff.timing
                        : 8'h00;
      if (sfr_wr_i && sfr_addr_i == EMT_TIMING_OFFSET)
         nxt_r.timing = sfr_wdata_i;
      if (on_pend_ff)
      begin
         nxt_r.done  = 1'b1;
         nxt_r.rdata = xram_q;
      end
      if (req_i && !r_ff.active && !on_pend_ff)
      begin
         if (go_off)
         begin
            nxt_r.active   = 1'b1;
            nxt_r.wr       = req_write_i;
            nxt_r.mux      = mux_mode;
            nxt_r.drive_hi = hi_drv;
            nxt_r.addr     = eff_addr;
            nxt_r.wdata    = req_wdata_i;
         end
         else
            nxt_on_pend = 1'b1;
      end
      nxt_r.offchip = r_ff.active;
      // Pins follow the sequencer phase
      nxt_r.ale        = 1'b0;
      nxt_r.rd_n       = 1'b1;
      nxt_r.wr_n       = 1'b1;
      nxt_r.addr_hi_oe = 1'b0;
      nxt_r.addr_lo_oe = 1'b0;
      nxt_r.dout_oe    = 1'b0;
      if (r_ff.active && sif.busy)
      begin
         nxt_r.addr_hi    = r_ff.addr[15:8];
         nxt_r.addr_hi_oe = r_ff.drive_hi;
         nxt_r.addr_lo    = r_ff.addr[7:0];
         nxt_r.addr_lo_oe = !r_ff.mux;
         case (sif.phase)
            EMT_ST_ALEHI:
            begin
               nxt_r.ale     = 1'b1;
               nxt_r.dout    = r_ff.addr[7:0];
               nxt_r.dout_oe = 1'b1;
            end
            EMT_ST_STROBE:
            begin
               nxt_r.rd_n    = r_ff.wr;
               nxt_r.wr_n    = !r_ff.wr;
               nxt_r.dout    = r_ff.wdata;
               nxt_r.dout_oe = r_ff.wr;
            end
            EMT_ST_SETUP, EMT_ST_HOLD:
            begin
               nxt_r.dout    = r_ff.wdata;
               nxt_r.dout_oe = r_ff.wr;
            end
            default:
               nxt_r.dout_oe = 1'b0;
         endcase
         // Sample while the read strobe is low on the pins
         if (!r_ff.rd_n && !r_ff.wr)
            nxt_r.rdata = data_i;
      end
      if (r_ff.active && busy_d_ff && !sif.busy)
      begin
         nxt_r.active = 1'b0;
         nxt_r.done   = 1'b1;
      end
      if (!rst_n_i)
      begin
         nxt_r = '0;
         nxt_r.timing = EMT_TIMING_RESET;
         nxt_r.rd_n   = 1'b1;
         nxt_r.wr_n   = 1'b1;
         nxt_on_pend  = 1'b0;
      end
   end

   always_ff @(posedge core_clk_i)
   begin
      r_ff       <= nxt_r;
      on_pend_ff <= nxt_on_pend;
   end

   // Start the sequencer the cycle after the request is latched
   assign sif.start      = r_ff.active && !sif.busy && !busy_d_ff;
   assign sif.is_mux     = r_ff.mux;
   assign sif.setup_cnt  = r_ff.timing[EMT_SETUP_MSB:EMT_SETUP_LSB];
   assign sif.strobe_cnt = r_ff.timing[EMT_STROBE_MSB:EMT_STROBE_LSB];
   assign sif.hold_cnt   = r_ff.timing[EMT_HOLD_MSB:EMT_HOLD_LSB];
   assign sif.ale_cnt    = interface_config_reg_i[EMT_ALE_MSB:EMT_ALE_LSB];

   assign sfr_rdata_o  = r_ff.sfr_rdata;
   assign done_o       = r_ff.done;
   assign rdata_o      = r_ff.rdata;
   assign offchip_o    = r_ff.offchip;
   assign addr_hi_o    = r_ff.addr_hi;
   assign addr_hi_oe_o = r_ff.addr_hi_oe;
   assign addr_lo_o    = r_ff.addr_lo;
   assign addr_lo_oe_o = r_ff.addr_lo_oe;
   assign data_o       = r_ff.dout;
   assign data_oe_o    = r_ff.dout_oe;
   assign ale_o        = r_ff.ale;
   assign rd_n_o       = r_ff.rd_n;
   assign wr_n_o       = r_ff.wr_n;
endmodule
`default_nettype wire

//--- hw/emt_pkg.sv
/*
 * Shared constants and types for the external data memory interface.
 * Assumes a single system clock and a synchronous active-low reset.
 */
package emt_pkg;
   localparam logic [7:0] EMT_TIMING_OFFSET  = 8'haa;
   localparam logic [7:0] EMT_TIMING_RESET   = 8'hff;
   localparam int         EMT_SETUP_MSB      = 7;
   localparam int         EMT_SETUP_LSB      = 6;
   localparam int         EMT_STROBE_MSB     = 5;
   localparam int         EMT_STROBE_LSB     = 2;
   localparam int         EMT_HOLD_MSB       = 1;
   localparam int         EMT_HOLD_LSB       = 0;
   localparam int         EMT_MUX_BIT        = 4;
   localparam int         EMT_MODE_MSB       = 3;
   localparam int         EMT_MODE_LSB       = 2;
   localparam int         EMT_ALE_MSB        = 1;
   localparam int         EMT_ALE_LSB        = 0;
   localparam logic [3:0] EMT_FIXED_CYCLES   = 4'h4;
   localparam int         EMT_XRAM_BYTES     = 4096;
   localparam int         EMT_XRAM_AW        = 12;

   typedef enum logic [1:0]
   {
      EMT_MAP_INTERNAL = 2'b00,
      EMT_MAP_SPLIT    = 2'b01,
      EMT_MAP_BANK     = 2'b10,
      EMT_MAP_EXTERNAL = 2'b11
   } emt_map_type;

   typedef enum logic [2:0]
   {
      EMT_ST_IDLE   = 3'b000,
      EMT_ST_ALEHI  = 3'b001,
      EMT_ST_ALELO  = 3'b010,
      EMT_ST_SETUP  = 3'b011,
      EMT_ST_STROBE = 3'b100,
      EMT_ST_HOLD   = 3'b101,
      EMT_ST_TAIL   = 3'b110
   } emt_state_type;
endpackage

//--- hw/emt_seq_if.sv
/*
 * Carrier between the access decoder and the bus sequencer.
 * Assumes both ends share the system clock.
 */
`timescale 1ns/1ps
`default_nettype none
interface emt_seq_if;
   logic       start;
   logic       is_mux;
   logic [1:0] setup_cnt;
   logic [3:0] strobe_cnt;
   logic [1:0] hold_cnt;
   logic [1:0] ale_cnt;
   logic       busy;
   logic [2:0] phase;

   modport ctrl (output start, is_mux, setup_cnt, strobe_cnt, hold_cnt,
                 ale_cnt, input busy, phase);
   modport seq  (input start, is_mux, setup_cnt, strobe_cnt, hold_cnt,
                 ale_cnt, output busy, phase);
endinterface
`default_nettype wire

//--- hw/emt_seq.sv
/*
 * Phase sequencer for one off-chip cycle: latch, setup, strobe, hold, tail.
 * Assumes start pulses only while busy is low.
 */
`timescale 1ns/1ps
`default_nettype none
module emt_seq
(
   input  wire logic core_clk_i,
   input  wire logic rst_n_i,
   emt_seq_if.seq    sif
);
   import emt_pkg::*;

   typedef struct packed
   {
      emt_state_type st;
      logic [3:0]    cnt;
      logic          mux;
      logic [1:0]    setup;
      logic [3:0]    strobe;
      logic [1:0]    hold;
      logic [1:0]    ale;
   } emt_sq_type;

   emt_sq_type s_ff;
   emt_sq_type nxt_s;

   always_comb
   begin
      nxt_s = s_ff;
      nxt_s.cnt = s_ff.cnt - 4'h1;
      case (s_ff.st)
         EMT_ST_IDLE:
         begin
            nxt_s.cnt = 4'h0;
            if (sif.start)
            begin
               nxt_s.mux    = sif.is_mux;
               nxt_s.setup  = sif.setup_cnt;
               nxt_s.strobe = sif.strobe_cnt;
               nxt_s.hold   = sif.hold_cnt;
               nxt_s.ale    = sif.ale_cnt;
               // Latch phase high then low, each code plus one cycles
               if (sif.is_mux)
               begin
                  nxt_s.st  = EMT_ST_ALEHI;
                  nxt_s.cnt = {2'b00, sif.ale_cnt};
               end
               else
               begin
                  nxt_s.st  = EMT_ST_SETUP;
                  nxt_s.cnt = {2'b00, sif.setup_cnt};
               end
            end
         end
         EMT_ST_ALEHI:
            if (s_ff.cnt == 4'h0)
            begin
               nxt_s.st  = EMT_ST_ALELO;
               nxt_s.cnt = {2'b00, s_ff.ale};
            end
         EMT_ST_ALELO:
            if (s_ff.cnt == 4'h0)
            begin
               nxt_s.st  = EMT_ST_SETUP;
               nxt_s.cnt = {2'b00, s_ff.setup};
            end
         // Setup state always lasts one fixed cycle plus the code
         EMT_ST_SETUP:
            if (s_ff.cnt == 4'h0)
            begin
               nxt_s.st  = EMT_ST_STROBE;
               nxt_s.cnt = s_ff.strobe;
            end
         EMT_ST_STROBE:
            if (s_ff.cnt == 4'h0)
            begin
               nxt_s.st  = EMT_ST_HOLD;
               nxt_s.cnt = {2'b00, s_ff.hold};
            end
         EMT_ST_HOLD:
            if (s_ff.cnt == 4'h0)
            begin
               nxt_s.st  = EMT_ST_TAIL;
               nxt_s.cnt = EMT_FIXED_CYCLES - 4'h4;
            end
         EMT_ST_TAIL:
            if (s_ff.cnt == 4'h0)
               nxt_s.st = EMT_ST_IDLE;
         default:
            nxt_s.st = EMT_ST_IDLE;
      endcase
      if (!rst_n_i)
      begin
         nxt_s = '0;
         nxt_s.st = EMT_ST_IDLE;
      end
   end

   always_ff @(posedge core_clk_i)
      s_ff <= nxt_s;

   assign sif.busy  = (s_ff.st != EMT_ST_IDLE);
   assign sif.phase = s_ff.st;
endmodule
`default_nettype wire

//--- tb/emt_mem_model.sv
/* Behavioural external SRAM on the memory port, 256 bytes by low address.
   Assumes the bench resolves the shared data wire through this model. */
`timescale 1ns/1ps
`default_nettype none
module emt_mem_model
(
   input  wire logic       core_clk_i,
   input  wire logic [7:0] addr_lo_i,
   input  wire logic       addr_lo_oe_i,
   input  wire logic [7:0] bus_i,
   input  wire logic       bus_oe_i,
   input  wire logic       ale_i,
   input  wire logic       rd_n_i,
   input  wire logic       wr_n_i,
   output var logic  [7:0] data_o
);
   logic [7:0] mem [256];
   logic [7:0] lat_ff;
   logic [7:0] last_ff;
   logic [7:0] a;
   // Latched low byte in shared-pin mode
   assign a = addr_lo_oe_i ? addr_lo_i : lat_ff;
   always_ff @(posedge core_clk_i)
   begin
      if (ale_i)
         lat_ff <= bus_i;
      if (!wr_n_i)
         mem[a] <= bus_i;
      last_ff <= data_o;
   end
   // Released bus shows inverse of last value
   assign data_o = bus_oe_i ? bus_i : (!rd_n_i ? mem[a] : ~last_ff);
endmodule
`default_nettype wire

//--- tb/emt_monitor.sv
/* Port checker for emt_top.
   Bound into emt_top; one clock, synchronous active-low reset. */
`timescale 1ns/1ps
`default_nettype none
module emt_monitor
(
   input wire logic        core_clk_i,
   input wire logic        rst_n_i,
   input wire logic [7:0]  sfr_addr_i,
   input wire logic [7:0]  sfr_wdata_i,
   input wire logic        sfr_wr_i,
   input wire logic [7:0]  sfr_rdata_o,
   input wire logic [7:0]  interface_config_reg_i,
   input wire logic [7:0]  xram_page_register_i,
   input wire logic [7:0]  indirect_index_i,
   input wire logic [15:0] data_pointer_i,
   input wire logic        req_i,
   input wire logic        req_wide_i,
   input wire logic        offchip_o,
   input wire logic [7:0]  addr_hi_o,
   input wire logic        addr_hi_oe_o,
   input wire logic [7:0]  addr_lo_o,
   input wire logic        addr_lo_oe_o,
   input wire logic [7:0]  data_o,
   input wire logic        data_oe_o,
   input wire logic        ale_o,
   input wire logic        rd_n_o,
   input wire logic        wr_n_o
);
   wire logic [1:0] map = interface_config_reg_i[3:2];
   wire logic       nmx = interface_config_reg_i[4];
   wire logic       strb = !rd_n_o || !wr_n_o;
   logic [7:0] tc_ff;
   logic [4:0] sc_ff;
   logic [2:0] ac_ff;
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!rst_n_i);
   // Shadow timing register and phase width counters
   always_ff @(posedge core_clk_i)
   begin
      if (!rst_n_i)
      begin
         tc_ff <= 8'hff;
         sc_ff <= 5'h00;
         ac_ff <= 3'h0;
      end
      else
      begin
         if (sfr_wr_i && sfr_addr_i == 8'haa)
            tc_ff <= sfr_wdata_i;
         sc_ff <= strb ? sc_ff + 5'h01 : 5'h00;
         ac_ff <= ale_o ? ac_ff + 3'h1 : 3'h0;
      end
   end
   property p_reg;
      !$past(sfr_wr_i) |-> sfr_rdata_o ==
         ($past(sfr_addr_i) == 8'haa ? $past(tc_ff) : 8'h00);
   endproperty
   a_reg: assert property (p_reg) else $error("timing readback");
   property p_int;
      req_i && !offchip_o && map == 2'b00 |=> !offchip_o [*4];
   endproperty
   a_int: assert property (p_int) else $error("bus cycle in mode 0");
   property p_ext;
      req_i && !offchip_o && map == 2'b11 |-> ##2 offchip_o;
   endproperty
   a_ext: assert property (p_ext) else $error("mode 3 stayed on-chip");
   property p_split;
      req_i && !offchip_o && req_wide_i && (map == 2'b01 || map == 2'b10)
         |-> ##2 offchip_o == ($past(data_pointer_i, 2) >= 16'h1000);
   endproperty
   a_split: assert property (p_split) else $error("split decode");
   property p_hi_off;
      strb && !req_wide_i && map != 2'b10 |-> !addr_hi_oe_o &&
         (!nmx || addr_lo_o == indirect_index_i);
   endproperty
   a_hi_off: assert property (p_hi_off) else $error("upper lines");
   property p_wide;
      strb && req_wide_i |-> addr_hi_oe_o &&
         addr_hi_o == data_pointer_i[15:8] &&
         (!nmx || addr_lo_oe_o && addr_lo_o == data_pointer_i[7:0]);
   endproperty
   a_wide: assert property (p_wide) else $error("wide address");
   property p_bank;
      strb && !req_wide_i && map == 2'b10 |-> addr_hi_oe_o &&
         addr_hi_o == xram_page_register_i &&
         (!nmx || addr_lo_oe_o && addr_lo_o == indirect_index_i);
   endproperty
   a_bank: assert property (p_bank) else $error("bank address");
   property p_ale;
      ale_o |-> data_oe_o && !addr_lo_oe_o && data_o ==
         (req_wide_i ? data_pointer_i[7:0] : indirect_index_i);
   endproperty
   a_ale: assert property (p_ale) else $error("latch phase");
   property p_alew;
      !ale_o && ac_ff != 3'h0 |->
         ac_ff == {1'b0, interface_config_reg_i[1:0]} + 3'h1;
   endproperty
   a_alew: assert property (p_alew) else $error("latch width");
   property p_strw;
      !strb && sc_ff != 5'h00 |-> sc_ff == {1'b0, tc_ff[5:2]} + 5'h01;
   endproperty
   a_strw: assert property (p_strw) else $error("strobe width");
endmodule
bind emt_top emt_monitor mon (.*);
`default_nettype wire

//--- tb/tb_external_memory_mode_and_timing.sv
/* Self-checking bench for emt_top with an SRAM model on the port.
   Assumes 25 MHz system clock and synchronous active-low reset. */
`timescale 1ns/1ps
`default_nettype none
module tb_external_memory_mode_and_timing;
   logic core_clk_i = 1'b0, rst_n_i = 1'b0, sfr_wr_i = 1'b0, req_i = 1'b0;
   logic req_wide_i = 1'b0, req_write_i = 1'b0;
   logic [7:0] sfr_addr_i = 8'h00, sfr_wdata_i = 8'h00, req_wdata_i = 8'h00;
   logic [7:0] interface_config_reg_i = 8'h10, xram_page_register_i = 8'h00;
   logic [7:0] indirect_index_i = 8'h00, data_i;
   logic [15:0] data_pointer_i = 16'h0000;
   logic [7:0] sfr_rdata_o, rdata_o, addr_hi_o, addr_lo_o, data_o, rd;
   logic done_o, offchip_o, addr_hi_oe_o, addr_lo_oe_o, data_oe_o;
   logic ale_o, rd_n_o, wr_n_o, saw_lo, saw_ale;
   int fails = 0, tests_run = 0, len, base;
   logic [7:0] tv [7] = '{8'h40, 8'hc0, 8'h04, 8'h3c, 8'h01, 8'h03, 8'hff};
   emt_top uut (.*);
   emt_mem_model mem (.core_clk_i(core_clk_i), .addr_lo_i(addr_lo_o),
      .addr_lo_oe_i(addr_lo_oe_o), .bus_i(data_o), .bus_oe_i(data_oe_o),
      .ale_i(ale_o), .rd_n_i(rd_n_o), .wr_n_i(wr_n_o), .data_o(data_i));
   initial
   begin
      forever #20 core_clk_i = ~core_clk_i;
   end
   task automatic stop_test();
      $display("checks %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   initial
   begin
      #400000;
      fails++;
      stop_test();
   end
   task automatic chk(input logic [15:0] s, input logic [15:0] e);
      tests_run++;
      if (s !== e)
      begin
         fails++;
         $display("FAIL t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   task automatic sfr_w(input logic [7:0] a, input logic [7:0] d);
      sfr_addr_i <= a;
      sfr_wdata_i <= d;
      sfr_wr_i <= 1'b1;
      @(posedge core_clk_i);
      sfr_wr_i <= 1'b0;
      @(posedge core_clk_i);
   endtask
   task automatic sfr_r(input logic [7:0] a);
      sfr_addr_i <= a;
      @(posedge core_clk_i);
      @(negedge core_clk_i);
      rd = sfr_rdata_o;
      @(posedge core_clk_i);
   endtask
   // One move; counts off-chip cycles until done
   task automatic mv(input logic w, input logic wr, input logic [7:0] d,
                     input logic [7:0] p, input logic [7:0] i,
                     input logic [15:0] a);
      int n;
      xram_page_register_i <= p;
      indirect_index_i <= i;
      data_pointer_i <= a;
      req_wide_i <= w;
      req_write_i <= wr;
      req_wdata_i <= d;
      req_i <= 1'b1;
      @(posedge core_clk_i);
      req_i <= 1'b0;
      len = 0;
      saw_lo = 1'b0;
      saw_ale = 1'b0;
      for (n = 0; n < 200; n++)
      begin
         @(negedge core_clk_i);
         if (offchip_o === 1'b1)
            len++;
         if (addr_lo_oe_o === 1'b1)
            saw_lo = 1'b1;
         if (ale_o === 1'b1)
            saw_ale = 1'b1;
         if (done_o === 1'b1)
            break;
      end
      rd = rdata_o;
      @(posedge core_clk_i);
      chk(16'(n < 200), 16'h1);
   endtask
   task automatic t_regs();
      chk({rd_n_o, wr_n_o, done_o}, 16'h6);
      sfr_r(8'haa);
      chk(rd, 16'hff);
      sfr_w(8'haa, 8'h00);
      sfr_r(8'haa);
      chk(rd, 16'h00);
      sfr_r(8'h55);
      chk(rd, 16'h00);
   endtask
   task automatic t_maps();
      mv(0, 1, 8'ha5, 8'h10, 8'h05, 16'h0);
      chk(16'(len), 16'h0);
      mv(1, 0, 8'h00, 8'h00, 8'h00, 16'h2005);
      chk(rd, 16'ha5);
      interface_config_reg_i <= 8'h14;
      mv(1, 1, 8'h5a, 8'h00, 8'h00, 16'h1234);
      chk(16'(len != 0), 16'h1);
      mv(1, 0, 8'h00, 8'h00, 8'h00, 16'h0005);
      chk({rd, 8'(len)}, 16'ha500);
      mv(0, 1, 8'h77, 8'h12, 8'h34, 16'h0);
      chk(16'(saw_lo), 16'h1);
      mv(1, 0, 8'h00, 8'h00, 8'h00, 16'h1234);
      chk(rd, 16'h77);
      interface_config_reg_i <= 8'h18;
      mv(0, 0, 8'h00, 8'h12, 8'h34, 16'h0);
      chk(rd, 16'h77);
      mv(0, 0, 8'h00, 8'h00, 8'h05, 16'h0);
      chk({rd, 8'(len)}, 16'ha500);
      interface_config_reg_i <= 8'h1c;
      mv(1, 0, 8'h00, 8'h00, 8'h00, 16'h0034);
      chk({rd, 8'(len != 0)}, 16'h7701);
      mv(0, 0, 8'h00, 8'h00, 8'h34, 16'h0);
      chk({rd, 8'(len != 0)}, 16'h7701);
   endtask
   task automatic t_timing();
      mv(1, 0, 8'h00, 8'h00, 8'h00, 16'h0034);
      base = len;
      foreach (tv[k])
      begin
         sfr_w(8'haa, tv[k]);
         mv(1, 0, 8'h00, 8'h00, 8'h00, 16'h0034);
         chk(16'(len - base), 16'(tv[k][7:6]) + 16'(tv[k][5:2])
             + 16'(tv[k][1:0]));
      end
      sfr_w(8'haa, 8'h00);
   endtask
   task automatic t_mux();
      for (int k = 0; k < 4; k++)
      begin
         interface_config_reg_i <= 8'h0c | 8'(k);
         mv(1, 0, 8'h00, 8'h00, 8'h00, 16'h0034);
         chk(16'(len - base), 16'(2 * (k + 1)));
         chk({rd, 3'(saw_ale), 5'(saw_lo)}, 16'h7720);
      end
      interface_config_reg_i <= 8'h04;
      mv(0, 1, 8'h3c, 8'h12, 8'h56, 16'h0);
      mv(0, 0, 8'h00, 8'h12, 8'h56, 16'h0);
      chk(rd, 16'h3c);
   endtask
   initial
   begin
      repeat (3) @(posedge core_clk_i);
      rst_n_i <= 1'b1;
      @(posedge core_clk_i);
      t_regs();
      t_maps();
      t_timing();
      t_mux();
      stop_test();
   end
endmodule
`default_nettype wire
